// ===== rtl/clk_ctrl_pkg.sv
// constants and carrier types for the system clock prescaler and trim block
package clk_ctrl_pkg;

   // ==========================================================
   // register indexes (byte address is four times the index)
   localparam logic [7:0] IDX_CLOCK_PRESCALE = 8'h61;
   localparam logic [7:0] IDX_RC_OSC_TRIM = 8'h66;
   localparam logic [7:0] IDX_TIMER_OSC_CTRL = 8'h6E;
   localparam int ADR_W = 10;
   localparam logic [ADR_W-1:0] ADR_CLOCK_PRESCALE = {IDX_CLOCK_PRESCALE, 2'b00};
   localparam logic [ADR_W-1:0] ADR_RC_OSC_TRIM = {IDX_RC_OSC_TRIM, 2'b00};
   localparam logic [ADR_W-1:0] ADR_TIMER_OSC_CTRL = {IDX_TIMER_OSC_CTRL, 2'b00};

   // ==========================================================
   // field positions
   localparam int PCE_BIT = 7;
   localparam int SEL_LSB = 0;
   localparam int SEL_W = 4;
   localparam int RANGE_BIT = 7;
   localparam int EXT_CLK_BIT = 0;
   localparam int TOSC_REQ_BIT = 1;
   localparam int RC_SEL_BIT = 2;
   localparam int TOSC_RUN_BIT = 3;

   // ==========================================================
   // reset values and magic values
   localparam logic [3:0] SEL_RESET_NODIV = 4'h0;
   localparam logic [3:0] SEL_RESET_DIV8 = 4'h3;
   localparam logic [3:0] SEL_MAX_VALID = 4'h8;
   localparam logic [7:0] PCE_ARM_VALUE = 8'h80;
   localparam logic [7:0] DIV_LAST_RESERVED = 8'hFF;
   localparam logic [7:0] TRIM_RESET_FALLBACK = 8'h00;
   localparam logic [1:0] TOSC_CTRL_RESET = 2'h0;

   // ==========================================================
   // timing: change window measured in prescaler ticks
   localparam logic [2:0] PCE_WINDOW_CYCLES = 3'h4;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic change_en;
      logic [2:0] unused;
      logic [3:0] select;
   } prescale_reg_t;

   typedef struct packed {
      logic core;
      logic program_memory;
      logic peripheral_io;
   } clock_enables_t;

   typedef enum logic [1:0] {
      PCE_CLOSED = 2'b00,
      PCE_OPEN = 2'b01
   } pce_state_t;

endpackage

// ===== rtl/system_clock_prescale_and_trim.sv
// system clock prescaler, rc oscillator trim, clock output and timer osc pin control
`timescale 1ns/100ps
// ==========================================================
module system_clock_prescale_and_trim
   import clk_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // classic wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // fuses and factory data (static pins)
   input wire logic divide_by_eight_fuse_i,
   input wire logic clock_out_fuse_i,
   input wire logic [7:0] factory_trim_i,
   // clock source status from the source selector
   input wire logic rc_osc_selected_i,
   // generated clock enables
   output clock_enables_t clk_en_o,
   // clock output pin
   output logic clock_out_pin_o,
   output logic clock_out_pin_oe_n_o,
   // oscillator trim
   output logic osc_range_select_o,
   output logic [6:0] osc_fine_trim_o,
   // timer oscillator pins
   output logic timer_osc_enable_o,
   output logic timer_osc_ext_clock_o,
   output logic crystal_pins_to_timer_o
);

   // ==========================================================
   // fuse and factory pin synchronisers
   // no reset here so the straps are valid while reset is still held
   logic [1:0] div8_sync_ff;
   logic [1:0] clock_out_fuse_sync_ff;
   logic [7:0] trim_meta_ff;
   logic [7:0] trim_sync_ff;

   always_ff @(posedge clk_i) begin
      div8_sync_ff <= {div8_sync_ff[0], divide_by_eight_fuse_i};
      clock_out_fuse_sync_ff <= {clock_out_fuse_sync_ff[0], clock_out_fuse_i};
      trim_meta_ff <= factory_trim_i;
      trim_sync_ff <= trim_meta_ff;
   end

   // ==========================================================
   // wishbone slave: one wait state, ack for one cycle
   logic ack_ff;
   logic [31:0] dat_ff;
   logic req;
   logic wr_take;
   logic hit_prescale;
   logic hit_trim;
   logic hit_tosc;

   assign req = cyc_i & stb_i;
   assign hit_prescale = (adr_i == ADR_CLOCK_PRESCALE);
   assign hit_trim = (adr_i == ADR_RC_OSC_TRIM);
   assign hit_tosc = (adr_i == ADR_TIMER_OSC_CTRL);
   // writes land on the edge where the master sees ack
   assign wr_take = req & we_i & ack_ff & sel_i[0];

   logic nxt_ack;
   assign nxt_ack = req & ~ack_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= nxt_ack;
      end
   end

   assign ack_o = ack_ff;
   assign dat_o = dat_ff;

   // ==========================================================
   // prescaler state
   logic [3:0] sel_ff;        // software visible select
   logic [3:0] active_sel_ff; // select the divider is running
   logic pend_ff;
   pce_state_t pce_ff;
   logic [2:0] pce_cnt_ff;
   logic [7:0] cnt_ff;
   logic [7:0] div_last;
   logic [7:0] div_half;
   logic tick;
   logic [7:0] wr_byte;
   logic arm_write;
   logic sel_write;

   assign wr_byte = dat_i[7:0];
   assign arm_write = wr_take & hit_prescale & (wr_byte == PCE_ARM_VALUE);
   assign sel_write = wr_take & hit_prescale & ~wr_byte[PCE_BIT];

   // reserved codes run at the slowest valid rate rather than an undefined one
   always_comb begin
      div_last = DIV_LAST_RESERVED;
      if (active_sel_ff <= SEL_MAX_VALID) begin
         div_last = 8'((9'h001 << active_sel_ff) - 9'h001);
      end
      div_half = 8'((9'(div_last) + 9'h001) >> 1);
   end

   // ==========================================================
   // divider counter at the undivided rate, never readable
   assign tick = (cnt_ff == div_last);

   logic [7:0] nxt_cnt;

   always_comb begin
      nxt_cnt = cnt_ff + 8'h01;
      if (tick) begin
         nxt_cnt = 8'h00;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_ff <= 8'h00;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   // ==========================================================
   // switch only at the end of an old period and restart the count,
   // so every period is a whole old or a whole new one
   logic [3:0] nxt_active_sel;
   logic nxt_pend;

   always_comb begin
      nxt_active_sel = active_sel_ff;
      nxt_pend = pend_ff;
      if (tick && pend_ff) begin
         nxt_active_sel = sel_ff;
      end
      if (pce_ff == PCE_OPEN && sel_write) begin
         nxt_pend = 1'b1;
      end else if (tick) begin
         nxt_pend = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         active_sel_ff <= div8_sync_ff[1] ? SEL_RESET_DIV8 : SEL_RESET_NODIV;
         pend_ff <= 1'b0;
      end else begin
         active_sel_ff <= nxt_active_sel;
         pend_ff <= nxt_pend;
      end
   end

   // one tick drives all three domains so they stay in step
   always_comb begin
      clk_en_o.core = tick;
      clk_en_o.program_memory = tick;
      clk_en_o.peripheral_io = tick;
   end

   // ==========================================================
   // select register
   logic [3:0] nxt_sel;

   always_comb begin
      nxt_sel = sel_ff;
      if (pce_ff == PCE_OPEN && sel_write) begin
         nxt_sel = wr_byte[SEL_LSB +: SEL_W];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_ff <= div8_sync_ff[1] ? SEL_RESET_DIV8 : SEL_RESET_NODIV;
      end else begin
         sel_ff <= nxt_sel;
      end
   end

   // ==========================================================
   // change enable window, counted in prescaler ticks
   pce_state_t nxt_pce;
   logic [2:0] nxt_pce_cnt;
   logic window_done;

   assign window_done = tick && (pce_cnt_ff == PCE_WINDOW_CYCLES - 3'h1);

   always_comb begin
      nxt_pce = pce_ff;
      nxt_pce_cnt = pce_cnt_ff;
      unique case (pce_ff)
         PCE_CLOSED: begin
            nxt_pce_cnt = 3'h0;
            if (arm_write) begin
               nxt_pce = PCE_OPEN;
            end
         end
         PCE_OPEN: begin
            // a second arm write is not seen here, so no restart
            if (sel_write || window_done) begin
               nxt_pce = PCE_CLOSED;
            end else if (tick) begin
               nxt_pce_cnt = pce_cnt_ff + 3'h1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pce_ff <= PCE_CLOSED;
         pce_cnt_ff <= 3'h0;
      end else begin
         pce_ff <= nxt_pce;
         pce_cnt_ff <= nxt_pce_cnt;
      end
   end

   // ==========================================================
   // oscillator trim
   logic [7:0] trim_ff;

   logic [7:0] nxt_trim;

   always_comb begin
      nxt_trim = trim_ff;
      if (wr_take && hit_trim) begin
         nxt_trim = wr_byte;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trim_ff <= trim_sync_ff;
      end else begin
         trim_ff <= nxt_trim;
      end
   end

   assign osc_range_select_o = trim_ff[RANGE_BIT];
   assign osc_fine_trim_o = trim_ff[6:0];

   // ==========================================================
   // timer oscillator control
   logic ext_clk_ff;
   logic tosc_req_ff;
   logic tosc_run;

   logic nxt_ext_clk;
   logic nxt_tosc_req;

   always_comb begin
      nxt_ext_clk = ext_clk_ff;
      nxt_tosc_req = tosc_req_ff;
      if (wr_take && hit_tosc) begin
         nxt_ext_clk = wr_byte[EXT_CLK_BIT];
         nxt_tosc_req = wr_byte[TOSC_REQ_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {tosc_req_ff, ext_clk_ff} <= TOSC_CTRL_RESET;
      end else begin
         ext_clk_ff <= nxt_ext_clk;
         tosc_req_ff <= nxt_tosc_req;
      end
   end

   // the pins belong to the crystal unless the timer osc is requested while the rc oscillator runs the chip
   assign tosc_run = tosc_req_ff & rc_osc_selected_i;
   assign timer_osc_enable_o = tosc_run & ~ext_clk_ff;
   assign timer_osc_ext_clock_o = tosc_run & ext_clk_ff;
   assign crystal_pins_to_timer_o = tosc_run;

   // ==========================================================
   // clock output pin; at divide by one the pin is held high because
   // a flop cannot reproduce the undivided clock
   logic clkout_ff;

   logic nxt_clkout;

   always_comb begin
      nxt_clkout = (cnt_ff < div_half);
      if (active_sel_ff == SEL_RESET_NODIV) begin
         nxt_clkout = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clkout_ff <= 1'b0;
      end else begin
         clkout_ff <= nxt_clkout;
      end
   end

   // fuse owns the pin from reset onward
   assign clock_out_pin_o = clkout_ff;
   assign clock_out_pin_oe_n_o = ~clock_out_fuse_sync_ff[1];

   // ==========================================================
   // read data, taken in the request cycle; unmapped reads give zero
   prescale_reg_t pr_view;

   always_comb begin
      pr_view.change_en = (pce_ff == PCE_OPEN);
      pr_view.unused = 3'h0;
      pr_view.select = sel_ff;
   end

   logic [31:0] nxt_dat;

   always_comb begin
      nxt_dat = 32'h0000_0000;
      if (hit_prescale) begin
         nxt_dat[7:0] = pr_view;
      end else if (hit_trim) begin
         nxt_dat[7:0] = trim_ff;
      end else if (hit_tosc) begin
         nxt_dat[EXT_CLK_BIT] = ext_clk_ff;
         nxt_dat[TOSC_REQ_BIT] = tosc_req_ff;
         nxt_dat[RC_SEL_BIT] = rc_osc_selected_i;
         nxt_dat[TOSC_RUN_BIT] = tosc_run;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_ff <= 32'h0000_0000;
      end else if (req && !ack_ff) begin
         dat_ff <= nxt_dat;
      end
   end

endmodule // system_clock_prescale_and_trim

// ===== test/system_clock_prescale_and_trim_properties.sv
// assertions for the clock prescaler and trim block
`timescale 1ns/100ps
module system_clock_prescale_and_trim_properties
   import clk_ctrl_pkg::*;
(
   // watched ports, grouped to keep the file short
   input wire logic clk_i, rst_i, cyc_i, stb_i, we_i, clock_out_fuse_i, rc_osc_selected_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o, clock_out_pin_oe_n_o, osc_range_select_o,
   input wire logic timer_osc_enable_o, timer_osc_ext_clock_o, crystal_pins_to_timer_o,
   input wire logic [6:0] osc_fine_trim_o,
   input wire clock_enables_t clk_en_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========================================================
   // cycles since the last tick; bounds the longest divided period
   logic [8:0] gap_ff;
   always_ff @(posedge clk_i) begin
      if (rst_i || clk_en_o.core) begin
         gap_ff <= 9'h000;
      end else begin
         gap_ff <= gap_ff + 9'h001;
      end
   end
   // ==========================================================
   // properties
   property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack not a single pulse");
   property p_en_same; clk_en_o.core == clk_en_o.program_memory
      && clk_en_o.core == clk_en_o.peripheral_io; endproperty
   a_en_same: assert property (p_en_same) else $error("clock enables differ");
   property p_xtal; crystal_pins_to_timer_o |-> rc_osc_selected_i; endproperty
   a_xtal: assert property (p_xtal) else $error("timer osc without rc source");
   property p_ext; timer_osc_ext_clock_o |-> crystal_pins_to_timer_o && !timer_osc_enable_o;
   endproperty
   a_ext: assert property (p_ext) else $error("ext clock mode wrong");
   property p_oe; $stable(clock_out_fuse_i) [*3] |-> clock_out_pin_oe_n_o == !clock_out_fuse_i;
   endproperty
   a_oe: assert property (p_oe) else $error("clock out enable wrong");
   property p_pre_rd; ack_o && !we_i && adr_i == ADR_CLOCK_PRESCALE
      |-> dat_o[6:4] == 3'h0 && dat_o[31:8] == 24'h000000; endproperty
   a_pre_rd: assert property (p_pre_rd) else $error("unused bits not zero");
   property p_trim_rd; ack_o && !we_i && adr_i == ADR_RC_OSC_TRIM
      |-> dat_o[7:0] == {osc_range_select_o, osc_fine_trim_o}; endproperty
   a_trim_rd: assert property (p_trim_rd) else $error("trim pins differ");
   property p_trim_wr; ack_o && we_i && sel_i[0] && adr_i == ADR_RC_OSC_TRIM
      |=> {osc_range_select_o, osc_fine_trim_o} == $past(dat_i[7:0]); endproperty
   a_trim_wr: assert property (p_trim_wr) else $error("trim write lost");
   property p_gap; gap_ff <= 9'h0FF; endproperty
   a_gap: assert property (p_gap) else $error("period above 256");
   c_ext: cover property (timer_osc_ext_clock_o);
   c_gap: cover property (gap_ff == 9'h0FF);
   c_trim: cover property (ack_o && we_i && adr_i == ADR_RC_OSC_TRIM);
endmodule // system_clock_prescale_and_trim_properties
bind system_clock_prescale_and_trim system_clock_prescale_and_trim_properties chk_u (
   .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .clock_out_fuse_i, .rc_osc_selected_i, .adr_i,
   .sel_i, .dat_i, .dat_o, .ack_o, .clock_out_pin_oe_n_o, .osc_range_select_o,
   .timer_osc_enable_o, .timer_osc_ext_clock_o, .crystal_pins_to_timer_o, .osc_fine_trim_o,
   .clk_en_o);

// ===== test/system_clock_prescale_and_trim_tb_top.sv
// self-checking bench for the clock prescaler and trim block
`timescale 1ns/100ps
module system_clock_prescale_and_trim_tb_top;
   import clk_ctrl_pkg::*;
   // ==========================================================
   // signals
   localparam logic [ADR_W-1:0] PR = ADR_CLOCK_PRESCALE;
   localparam logic [ADR_W-1:0] TR = ADR_RC_OSC_TRIM;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic divide_by_eight_fuse_i = 1'b0, clock_out_fuse_i = 1'b0, rc_osc_selected_i = 1'b0;
   logic [ADR_W-1:0] adr_i = '0;
   logic [3:0] sel_i = 4'h0;
   logic [3:0] code;
   logic [31:0] dat_i = '0;
   logic [31:0] dat_o, rd;
   logic [7:0] factory_trim_i = 8'h00;
   logic [7:0] trim;
   logic ack_o, clock_out_pin_o, clock_out_pin_oe_n_o, osc_range_select_o;
   logic timer_osc_enable_o, timer_osc_ext_clock_o, crystal_pins_to_timer_o;
   logic [6:0] osc_fine_trim_o;
   clock_enables_t clk_en_o;
   int err_count = 0, checked = 0, ticks = 0, n, h, f;
   always #5 clk_i = ~clk_i;
   system_clock_prescale_and_trim dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
      .dat_i, .dat_o, .ack_o, .divide_by_eight_fuse_i, .clock_out_fuse_i, .factory_trim_i,
      .rc_osc_selected_i, .clk_en_o, .clock_out_pin_o, .clock_out_pin_oe_n_o,
      .osc_range_select_o, .osc_fine_trim_o, .timer_osc_enable_o, .timer_osc_ext_clock_o,
      .crystal_pins_to_timer_o);
   // ==========================================================
   // tasks
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int exp);
      chk_reg(32'(got), 32'(exp));
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      ticks++;
      if (ticks == 60000) begin
         err_count++;
         test_done();
      end
   end
   task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [7:0] d,
                     input logic [3:0] s);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= {24'h000000, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic rdreg(input logic [ADR_W-1:0] a);
      wb(1'b0, a, 8'h00, 4'h1);
   endtask
   task automatic set_div(input logic [7:0] v);
      wb(1'b1, PR, PCE_ARM_VALUE, 4'h1); // nothing interleaves the two steps
      wb(1'b1, PR, v, 4'h1);
   endtask
   task automatic do_reset(input logic d8, input logic co);
      rst_i <= 1'b1;
      divide_by_eight_fuse_i <= d8;
      clock_out_fuse_i <= co;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask
   // skips the switching period, then counts one period and its high cycles on the pin
   task automatic measure;
      repeat (2) begin
         @(posedge clk_i);
         while (clk_en_o.core !== 1'b1) @(posedge clk_i);
      end
      n = 0;
      h = 0;
      do begin
         @(posedge clk_i);
         n++;
         if (clock_out_pin_o === 1'b1) begin
            h++;
         end else if (clock_out_pin_o !== 1'b0) begin
            h += 1000;
         end
      end while (clk_en_o.core !== 1'b1);
   endtask
   function automatic int fac(input logic [3:0] c);
      return (c > SEL_MAX_VALID) ? 256 : (1 << c);
   endfunction
   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(10126));
      factory_trim_i <= 8'($urandom);
      do_reset(1'b1, 1'b0);
      rdreg(PR);
      chk_reg(rd, 32'h03);
      measure();
      chk_cnt(n, 8);
      rdreg(TR);
      chk_reg(rd, {24'h0, factory_trim_i});
      chk_reg({31'h0, clock_out_pin_oe_n_o}, 32'h1);
      $display("test reset_div8 done");
      do_reset(1'b0, 1'b1);
      rdreg(PR);
      chk_reg(rd, 32'h00);
      chk_reg({31'h0, clock_out_pin_oe_n_o}, 32'h0);
      $display("test reset_plain done");
      code = 4'($urandom);
      for (int i = 0; i < 16; i++) begin
         code = code + 4'h1;
         f = fac(code);
         set_div({4'h0, code});
         rdreg(PR);
         chk_reg(rd, {28'h0, code});
         measure();
         chk_cnt(n, f);
         chk_cnt(h, (f == 1) ? 1 : f / 2);
      end
      $display("test divide_codes done");
      set_div(8'h04);
      wb(1'b1, PR, PCE_ARM_VALUE, 4'h1);
      wb(1'b1, PR, PCE_ARM_VALUE, 4'h1);
      rdreg(PR);
      chk_reg(rd, 32'h84);
      wb(1'b1, PR, 8'h72, 4'h1);
      rdreg(PR);
      chk_reg(rd, 32'h02);
      measure();
      chk_cnt(n, 4);
      set_div(8'h04);
      // window of four ticks at /16 is 48 to 64 cycles; a restart would push it past 79
      wb(1'b1, PR, PCE_ARM_VALUE, 4'h1);
      repeat (28) @(posedge clk_i);
      wb(1'b1, PR, PCE_ARM_VALUE, 4'h1);
      repeat (34) @(posedge clk_i);
      rdreg(PR);
      chk_reg(rd, 32'h04);
      wb(1'b1, PR, 8'h05, 4'h1);
      wb(1'b1, PR, 8'h81, 4'h1);
      rdreg(PR);
      chk_reg(rd, 32'h04);
      $display("test change_window done");
      for (int i = 0; i < 4; i++) begin
         trim = (i < 2) ? 8'h7F + 8'(i) : 8'($urandom);
         wb(1'b1, TR, trim, 4'h1); // no nonvolatile writes run here
         rdreg(TR);
         chk_reg({25'h0, osc_range_select_o, osc_fine_trim_o}, {24'h0, trim});
      end
      wb(1'b1, TR, ~trim, 4'hE);
      rdreg(TR);
      chk_reg(rd, {24'h0, trim});
      wb(1'b1, 10'h3FC, 8'hFF, 4'h1);
      rdreg(10'h3FC);
      chk_reg(rd, 32'h0);
      $display("test trim_bus done");
      for (int i = 0; i < 8; i++) begin
         rc_osc_selected_i <= i[2]; // bench clock far above any timer osc rate
         wb(1'b1, ADR_TIMER_OSC_CTRL, {6'h0, i[1], i[0]}, 4'h1);
         @(posedge clk_i);
         chk_reg({29'h0, crystal_pins_to_timer_o, timer_osc_ext_clock_o, timer_osc_enable_o},
                 {29'h0, i[1] & i[2], i[1] & i[2] & i[0], i[1] & i[2] & ~i[0]});
         rdreg(ADR_TIMER_OSC_CTRL);
         chk_reg(rd, {28'h0, i[1] & i[2], i[2], i[1], i[0]});
      end
      $display("test timer_osc done");
      test_done();
   end
endmodule // system_clock_prescale_and_trim_tb_top
